// >>> rtl/mets_pkg.sv
/*
 * Package for the modulation edge timing register block: register
 * indices, field positions, reset values and shared timing and step flag types.
 * Assumes a classic Wishbone slave with 32-bit data, one register
 * per aligned word, byte address equal to the space base plus four times the index.
 */
package mets_pkg;

    localparam int unsigned ADR_W = 9;

    // Space B sits above space A in the byte address map
    localparam logic [ADR_W-1:0] SPACE_B_BASE = 9'h100;

    localparam logic [5:0] IDX_AMP_CFG      = 6'h33;
    localparam logic [5:0] IDX_AMP_AVG      = 6'h35;
    localparam logic [5:0] IDX_AMP_RESULT   = 6'h36;
    localparam logic [5:0] IDX_CLAMP_REL    = 6'h34;
    localparam logic [5:0] IDX_SUPPLY_RES   = 6'h35;
    localparam logic [5:0] IDX_STOP_SUPPLY  = 6'h36;
    localparam logic [5:0] IDX_CLAMP_CON    = 6'h37;
    localparam logic [5:0] IDX_DRIVE_RES    = 6'h38;
    localparam logic [5:0] IDX_RC_TRIM      = 6'h39;

    localparam int unsigned FLD_LO    = 0;
    localparam int unsigned FLD_HI    = 4;
    localparam int unsigned FLD_W     = 4;
    localparam int unsigned WCODE_POS = 1;
    localparam int unsigned WCODE_W   = 2;
    localparam int unsigned TRIM_W    = 3;

    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [2:0] WEIGHT_SHIFT0 = 3'h2;
    localparam int unsigned N_START_STEPS = 3;
    localparam int unsigned N_END_STEPS   = 4;

    typedef struct packed {
        logic [3:0] clamp_release_time;
        logic [3:0] supply_mod_start_time;
        logic [3:0] mod_resistance_time;
        logic [3:0] drive_stop_time;
        logic [3:0] rf_supply_switch_time;
        logic [3:0] clamp_connect_time;
        logic [3:0] drive_resistance_time;
    } mets_timing_s;

    typedef struct packed {
        logic mod_resistance;
        logic on_mod_supply;
        logic clamp_released;
    } mets_start_steps_s;

    typedef struct packed {
        logic drive_resistance;
        logic clamp_connected;
        logic on_rf_supply;
        logic drive_stopped;
    } mets_end_steps_s;

endpackage

// >>> rtl/mets_seq.sv
/*
 * Step sequencer for one modulation edge: a carrier-period counter
 * started by the edge, with one sticky step flag per programmed time.
 * Assumes carrier_tick_i is a one-cycle pulse on clk_i per carrier
 * period and that start_i and clear_i are pulses on clk_i.
 */
`timescale 1ns/100ps
module mets_seq
    import mets_pkg::*;
#(
    parameter int unsigned N_STEPS = 3,
    parameter int unsigned CNT_W   = 4
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          start_i,
    input  wire logic                          clear_i,
    input  wire logic                          carrier_tick_i,
    input  wire logic [N_STEPS-1:0][CNT_W-1:0] step_time_i,
    output logic      [N_STEPS-1:0]            step_done_o,
    output logic                               busy_o
);

    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    logic [CNT_W-1:0] periods_q;

    // Runs until the counter has swept every possible field value
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            busy_o <= 1'b0;
        end else if (start_i) begin
            busy_o <= 1'b1;
        end else if (carrier_tick_i && periods_q == CNT_MAX) begin
            busy_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || start_i) begin
            periods_q <= '0;
        end else if (busy_o && carrier_tick_i && periods_q != CNT_MAX) begin
            periods_q <= periods_q + 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_STEPS; g++) begin : g_step
            always_ff @(posedge clk_i) begin
                if (rst_i || clear_i || start_i) begin
                    step_done_o[g] <= 1'b0;
                end else if (busy_o && periods_q == step_time_i[g]) begin
                    step_done_o[g] <= 1'b1;
                end
            end
        end
    endgenerate

endmodule

// >>> rtl/mets_top.sv
/*
 * Modulation edge timing registers with their two step sequencers,
 * the amplitude result and auto-average readouts and the RC trim
 * readout, behind a classic Wishbone slave.
 * Assumes the modulation edges, carrier tick, amplitude samples and
 * trim value all come from logic on clk_i.
 */
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
module mets_top
    import mets_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADR_W-1:0]      wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  carrier_tick_i,
    input  wire logic                  mod_start_i,
    input  wire logic                  mod_end_i,
    input  wire logic                  amp_valid_i,
    input  wire logic [7:0]            amplitude_sample_value_i,
    input  wire logic [TRIM_W-1:0]     rc_trim_value_i,
    output mets_start_steps_s          start_steps_o,
    output mets_end_steps_s            end_steps_o,
    output logic                       start_busy_o,
    output logic                       end_busy_o
);

    logic [7:0]         clamp_release_timing_q;
    logic [7:0]         supply_and_resistance_timing_q;
    logic [7:0]         drive_stop_and_supply_timing_q;
    logic [7:0]         clamp_connect_timing_q;
    logic [7:0]         drive_resistance_timing_q;
    logic [WCODE_W-1:0] average_weight_code_q;
    logic [7:0]         amp_result_q;
    logic [7:0]         amp_avg_q;
    logic [7:0]         amp_avg_d;
    logic [TRIM_W-1:0]  rc_trim_q;
    logic [31:0]        rd_data_d;
    mets_timing_s       timing;

    logic       req;
    logic       wr_en;
    logic       space_b;
    logic [5:0] idx;
    logic       addr_ok;

    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign addr_ok = wb_adr_i[1:0] == 2'b00;
    assign space_b = wb_adr_i[8];
    assign idx     = wb_adr_i[7:2];
    // Upper byte lanes hold no bits, so only lane 0 can write
    assign wr_en   = req && wb_we_i && wb_sel_i[0] && addr_ok;

    // Ack one cycle after the strobe, dropped for one cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clamp_release_timing_q         <= REG_RESET;
            supply_and_resistance_timing_q <= REG_RESET;
            drive_stop_and_supply_timing_q <= REG_RESET;
            clamp_connect_timing_q         <= REG_RESET;
            drive_resistance_timing_q      <= REG_RESET;
        end else if (wr_en && space_b) begin
            unique case (idx)
                IDX_CLAMP_REL:   clamp_release_timing_q <= wb_dat_i[7:0];
                IDX_SUPPLY_RES:  begin
                    supply_and_resistance_timing_q <= wb_dat_i[7:0];
                end
                IDX_STOP_SUPPLY: begin
                    drive_stop_and_supply_timing_q <= wb_dat_i[7:0];
                end
                IDX_CLAMP_CON:   clamp_connect_timing_q <= wb_dat_i[7:0];
                IDX_DRIVE_RES:   drive_resistance_timing_q <= wb_dat_i[7:0];
                // Trim readout and unmapped words drop the write
                default:         ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            average_weight_code_q <= '0;
        end else if (wr_en && !space_b && idx == IDX_AMP_CFG) begin
            average_weight_code_q <= wb_dat_i[WCODE_POS +: WCODE_W];
        end
    end

    // Reserved bits are stored as written; software keeps them zero
    always_comb begin
        timing.clamp_release_time    = clamp_release_timing_q[FLD_LO +: FLD_W];
        timing.supply_mod_start_time = supply_and_resistance_timing_q[FLD_HI +: FLD_W];
        timing.mod_resistance_time   = supply_and_resistance_timing_q[FLD_LO +: FLD_W];
        timing.drive_stop_time       = drive_stop_and_supply_timing_q[FLD_HI +: FLD_W];
        timing.rf_supply_switch_time = drive_stop_and_supply_timing_q[FLD_LO +: FLD_W];
        timing.clamp_connect_time    = clamp_connect_timing_q[FLD_LO +: FLD_W];
        timing.drive_resistance_time = drive_resistance_timing_q[FLD_HI +: FLD_W];
    end

    // A new modulation start abandons any unfinished end sequence
    mets_seq #(
        .N_STEPS (N_START_STEPS),
        .CNT_W   (FLD_W)
    ) u_start_seq (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .start_i        (mod_start_i),
        .clear_i        (mod_end_i),
        .carrier_tick_i (carrier_tick_i),
        .step_time_i    ({timing.mod_resistance_time,
                          timing.supply_mod_start_time,
                          timing.clamp_release_time}),
        .step_done_o    (start_steps_o),
        .busy_o         (start_busy_o)
    );

    mets_seq #(
        .N_STEPS (N_END_STEPS),
        .CNT_W   (FLD_W)
    ) u_end_seq (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .start_i        (mod_end_i),
        .clear_i        (mod_start_i),
        .carrier_tick_i (carrier_tick_i),
        .step_time_i    ({timing.drive_resistance_time,
                          timing.clamp_connect_time,
                          timing.rf_supply_switch_time,
                          timing.drive_stop_time}),
        .step_done_o    (end_steps_o),
        .busy_o         (end_busy_o)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_result_q <= REG_RESET;
        end else if (amp_valid_i) begin
            amp_result_q <= amplitude_sample_value_i;
        end
    end

    // Moves toward the sample by one weight-th of the difference
    always_comb begin
        logic [2:0]        shift;
        logic signed [9:0] diff;
        logic signed [9:0] step;
        logic signed [9:0] sum;
        shift = WEIGHT_SHIFT0 + {1'b0, average_weight_code_q};
        diff  = signed'({2'b00, amplitude_sample_value_i})
              - signed'({2'b00, amp_avg_q});
        step  = diff >>> shift;
        sum   = signed'({2'b00, amp_avg_q}) + step;
        amp_avg_d = sum[7:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_avg_q <= REG_RESET;
        end else if (amp_valid_i) begin
            amp_avg_q <= amp_avg_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_trim_q <= '0;
        end else begin
            rc_trim_q <= rc_trim_value_i;
        end
    end

    always_comb begin
        rd_data_d = 32'h0000_0000;
        if (addr_ok && space_b) begin
            unique case (idx)
                IDX_CLAMP_REL:   rd_data_d[7:0] = clamp_release_timing_q;
                IDX_SUPPLY_RES:  rd_data_d[7:0] = supply_and_resistance_timing_q;
                IDX_STOP_SUPPLY: rd_data_d[7:0] = drive_stop_and_supply_timing_q;
                IDX_CLAMP_CON:   rd_data_d[7:0] = clamp_connect_timing_q;
                IDX_DRIVE_RES:   rd_data_d[7:0] = drive_resistance_timing_q;
                IDX_RC_TRIM:     rd_data_d[TRIM_W-1:0] = rc_trim_q;
                default:         rd_data_d = 32'h0000_0000;
            endcase
        end else if (addr_ok) begin
            unique case (idx)
                IDX_AMP_CFG: begin
                    rd_data_d[WCODE_POS +: WCODE_W] = average_weight_code_q;
                end
                IDX_AMP_AVG:    rd_data_d[7:0] = amp_avg_q;
                IDX_AMP_RESULT: rd_data_d[7:0] = amp_result_q;
                default:        rd_data_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req) begin
            wb_dat_o <= rd_data_d;
        end
    end

endmodule

// >>> tb/mets_top_asserts.sv
/* Port-level checks for mets_top: bus handshake and step sequencers.
   Assumes one clock domain with synchronous active-high rst_i. */
`timescale 1ns/100ps
module mets_top_asserts
    import mets_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic              carrier_tick_i,
    input wire logic              mod_start_i,
    input wire logic              mod_end_i,
    input wire mets_start_steps_s start_steps_o,
    input wire mets_end_steps_s   end_steps_o,
    input wire logic              start_busy_o,
    input wire logic              end_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Either edge clears both flag sets, so a restart is clean
    sequence s_start_armed;
        start_busy_o && start_steps_o == '0 && end_steps_o == '0;
    endsequence
    sequence s_end_armed;
        end_busy_o && start_steps_o == '0 && end_steps_o == '0;
    endsequence

    AST_ACK_NEXT: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_START_ARM: assert property (
        mod_start_i |=> s_start_armed) else $error("start edge not taken");
    AST_END_ARM: assert property (
        mod_end_i |=> s_end_armed) else $error("end edge not taken");
    AST_FLAG_HOLD: assert property (
        !mod_start_i && !mod_end_i |=>
        (start_steps_o & $past(start_steps_o)) == $past(start_steps_o) &&
        (end_steps_o & $past(end_steps_o)) == $past(end_steps_o))
        else $error("step flag dropped without edge");
    AST_CLAMP_BUSY: assert property (
        $rose(start_steps_o.clamp_released) |-> $past(start_busy_o))
        else $error("clamp release outside sequence");
    AST_STOP_BUSY: assert property (
        $rose(end_steps_o.drive_stopped) |-> $past(end_busy_o))
        else $error("drive stop outside sequence");
    AST_BUSY_HOLD: assert property (
        start_busy_o && !carrier_tick_i && !mod_end_i |=> start_busy_o)
        else $error("start busy dropped without tick");
    AST_BUSY_IDLE: assert property (
        !start_busy_o && !mod_start_i |=> !start_busy_o)
        else $error("start busy rose without edge");
endmodule

bind mets_top mets_top_asserts u_mets_top_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .carrier_tick_i(carrier_tick_i), .mod_start_i(mod_start_i),
    .mod_end_i(mod_end_i), .start_steps_o(start_steps_o),
    .end_steps_o(end_steps_o), .start_busy_o(start_busy_o),
    .end_busy_o(end_busy_o));

// >>> tb/mets_top_tb.sv
/* Self-checking bench for mets_top: registers, readouts, sequencers.
   Assumes the checker file is compiled alongside. */
`timescale 1ns/100ps
module mets_top_tb
    import mets_pkg::*;
;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic              tick = 1'b0, mstart = 1'b0, mend = 1'b0;
    logic              avalid = 1'b0;
    logic [3:0]        sel = 4'h0;
    logic [8:0]        adr = '0;
    logic [31:0]       wdat = '0;
    logic [7:0]        samp = '0;
    logic [2:0]        trim = '0;
    logic [31:0]       rdat;
    logic              ack, sbusy, ebusy;
    mets_start_steps_s ssteps;
    mets_end_steps_s   esteps;
    logic [7:0]        avg = '0;
    int                num_errors = 0, comparisons = 0, seed = 54166;

    mets_top u_mets_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .carrier_tick_i(tick),
        .mod_start_i(mstart), .mod_end_i(mend), .amp_valid_i(avalid),
        .amplitude_sample_value_i(samp), .rc_trim_value_i(trim),
        .start_steps_o(ssteps), .end_steps_o(esteps),
        .start_busy_o(sbusy), .end_busy_o(ebusy));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [7:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what,
                     got, exp);
        end
    endtask

    function automatic logic [8:0] ra(input bit b, input logic [5:0] i);
        return {b, i, 2'b00};
    endfunction

    // Request held until ack is sampled, then released
    task automatic bus(input logic w, input logic [8:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, sel} <= {2'b11, w, 4'h1};
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        chk({7'h0, ack}, 8'h01, "ack");
        q = rdat[7:0];
        {cyc, stb, we, sel} <= '0;
    endtask

    task automatic acc(input logic w, input logic [8:0] a,
                       input logic [7:0] d, e, input string what);
        logic [7:0] q;
        if (w) bus(1'b1, a, d, q);
        bus(1'b0, a, 8'h00, q);
        chk(q, e, what);
    endtask

    // One-hot {end, start, tick} pulse, then let flags settle
    task automatic pulse(input logic [2:0] p);
        {mend, mstart, tick} <= p;
        @(posedge clk_i);
        {mend, mstart, tick} <= 3'h0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic seq(input bit e, input logic [3:0][3:0] f);
        logic [3:0] x;
        if (!e && f[1] > f[0]) f[1] = f[0];
        if (e) begin
            // Upper nibble is the stop time (step 0), lower the switch
            acc(1, ra(1, IDX_STOP_SUPPLY), {f[0], f[1]}, {f[0], f[1]},
                "stop");
            acc(1, ra(1, IDX_CLAMP_CON), f[2], f[2], "con");
            acc(1, ra(1, IDX_DRIVE_RES), {f[3], 4'h0}, {f[3], 4'h0},
                "dres");
        end else begin
            acc(1, ra(1, IDX_CLAMP_REL), f[0], f[0], "rel");
            // Upper nibble is the supply start (step 1), lower resistance
            acc(1, ra(1, IDX_SUPPLY_RES), {f[1], f[2]}, {f[1], f[2]},
                "sup");
        end
        pulse(e ? 3'h4 : 3'h2);
        for (int k = 0; k < 17; k++) begin
            if (k > 0) pulse(3'h1);
            for (int i = 0; i < 4; i++) x[i] = f[i] <= k;
            if (e) chk({4'h0, esteps}, {4'h0, x}, "end");
            else chk({5'h0, ssteps}, {5'h0, x[2:0]}, "start");
            chk({7'h0, e ? ebusy : sbusy}, {7'h0, k < 16}, "busy");
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        $display("[FAIL] %0t watchdog expired", $time);
        num_errors++;
        close_out();
    end

    initial begin
        logic [7:0]      s;
        logic [3:0][3:0] f;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 'h33; i < 'h3a; i++) begin
            acc(0, ra(0, 6'(i)), 0, 8'h00, "reset A");
            acc(0, ra(1, 6'(i)), 0, 8'h00, "reset B");
        end
        $display("test reset done");
        for (int r = 0; r < 5; r++) begin
            f = r == 0 ? 16'h0 : r == 1 ? 16'hffff : 16'($random(seed));
            seq(0, f);
            seq(1, f);
        end
        $display("test sequencers done");
        for (int c = 0; c < 4; c++) begin
            acc(1, ra(0, IDX_AMP_CFG), 8'(c << 1), 8'(c << 1), "cfg");
            for (int j = 0; j < 6; j++) begin
                s = (j == 0) ? 8'hff : 8'($random(seed));
                avalid <= 1'b1;
                samp <= s;
                @(posedge clk_i);
                avalid <= 1'b0;
                avg = avg + 8'((int'(s) - int'(avg)) >>> (2 + c));
                acc(0, ra(0, IDX_AMP_RESULT), 0, s, "result");
                acc(0, ra(0, IDX_AMP_AVG), 0, avg, "average");
            end
        end
        $display("test amplitude done");
        acc(1, ra(0, IDX_AMP_AVG), 8'h5a, avg, "avg ro");
        acc(1, ra(0, IDX_AMP_RESULT), 8'h5a, s, "result ro");
        acc(1, ra(1, IDX_RC_TRIM), 8'h5a, 8'h00, "trim ro");
        acc(1, ra(0, 6'h3f), 8'h5a, 8'h00, "unmapped");
        for (int v = 0; v < 8; v++) begin
            trim <= 3'(v);
            repeat (2) @(posedge clk_i);
            acc(0, ra(1, IDX_RC_TRIM), 0, 8'(v), "trim");
        end
        $display("test readouts done");
        close_out();
    end
endmodule
